// [core/dvrs_pkg.sv]
// Package of constants for the voltage ramp and startup sequencer
package dvrs_pkg;
    localparam int CLK_HZ = 50000000;
    localparam int VID_W = 8;
    localparam int SECT_N = 2;
    localparam int PHASE_N = 6;
    // Reference step of one code, in microvolts
    localparam int STEP_UV = 5000;
    // Slopes in mV per microsecond
    localparam int SLOPE_FAST_MV_US = 20;
    localparam int SLOPE_SLOW_MV_US = 5;
    // Cycles per code step: ns per step = STEP_UV / slope; cycle count rounds down
    localparam int FAST_STEP_CYC = (STEP_UV / SLOPE_FAST_MV_US) * (CLK_HZ / 1000000) / 1000;
    localparam int SLOW_STEP_CYC = (STEP_UV / SLOPE_SLOW_MV_US) * (CLK_HZ / 1000000) / 1000;
    // Re-arm delay after a transition, in microseconds
    localparam int REARM_US = 2;
    localparam int REARM_CYC = REARM_US * (CLK_HZ / 1000000);
    localparam logic [VID_W-1:0] VID_OFF = 8'h00;
    localparam int GAIN_W = 8;
    localparam int CUR_W = 16;
    // Wishbone register byte addresses
    localparam logic [7:0] ADR_CMD = 8'h00;
    localparam logic [7:0] ADR_STAT = 8'h04;
    localparam logic [7:0] ADR_IRQ = 8'h08;
    localparam logic [7:0] ADR_MASK = 8'h0c;
    localparam logic [7:0] ADR_CFG = 8'h10;
    localparam logic [7:0] ADR_REF = 8'h14;
    // Command word fields
    localparam int CMD_VID_LSB = 0;
    localparam int CMD_SEC_BIT = 8;
    localparam int CMD_SLOW_BIT = 9;
    // Config fields
    localparam int CFG_GAIN_LSB = 0;
    localparam int CFG_DROOP_BIT = 8;
    localparam int CFG_MEM_BIT = 9;
    localparam logic [GAIN_W-1:0] GAIN_RST = 8'h80;
    // Interrupt event bits
    localparam int EV_DONE0 = 0;
    localparam int EV_DONE1 = 1;
    localparam int EV_REJ = 2;
    localparam int EV_LATCH = 3;
    localparam int EV_W = 4;
    typedef enum logic [1:0] {DVRS_OFF, DVRS_SOFT, DVRS_RUN, DVRS_LATCH} dvrs_st_t;
endpackage : dvrs_pkg

// [core/dvrs_ramp.sv]
// One section's reference ramp with protection mask timer
`timescale 1ns/10ps
module dvrs_ramp
    import dvrs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cmd_i,
    input wire logic slow_i,
    input wire logic [dvrs_pkg::VID_W-1:0] vid_i,
    output logic [dvrs_pkg::VID_W-1:0] ref_o,
    output logic busy_o,
    output logic mask_o,
    output logic done_o
);
    logic [VID_W-1:0] ref_q, ref_d, tgt_q, tgt_d;
    logic slow_q, slow_d, busy_q, busy_d, done_d;
    logic [15:0] cnt_q, cnt_d, arm_q, arm_d;
    always_comb begin
        ref_d = ref_q;
        tgt_d = tgt_q;
        slow_d = slow_q;
        busy_d = busy_q;
        cnt_d = cnt_q;
        arm_d = arm_q;
        done_d = 1'b0;
        if (arm_q != 16'h0000) begin
            arm_d = arm_q - 16'h0001;
        end
        if (cmd_i) begin
            tgt_d = vid_i;
            slow_d = slow_i;
            busy_d = (vid_i != ref_q);
            cnt_d = 16'h0000;
            arm_d = 16'h0000;
        end else if (busy_q) begin
            if (cnt_q == (slow_q ? 16'(SLOW_STEP_CYC - 1) : 16'(FAST_STEP_CYC - 1))) begin
                cnt_d = 16'h0000;
                ref_d = (tgt_q > ref_q) ? ref_q + 1'b1 : ref_q - 1'b1;
                if (ref_d == tgt_q) begin
                    busy_d = 1'b0;
                    done_d = 1'b1;
                    arm_d = 16'(REARM_CYC);
                end
            end else begin
                cnt_d = cnt_q + 16'h0001;
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_q <= VID_OFF;
            tgt_q <= VID_OFF;
            slow_q <= 1'b0;
            busy_q <= 1'b0;
            cnt_q <= 16'h0000;
            arm_q <= 16'h0000;
            done_o <= 1'b0;
        end else begin
            ref_q <= ref_d;
            tgt_q <= tgt_d;
            slow_q <= slow_d;
            busy_q <= busy_d;
            cnt_q <= cnt_d;
            arm_q <= arm_d;
            done_o <= done_d;
        end
    end
    assign ref_o = ref_q;
    assign busy_o = busy_q;
    assign mask_o = busy_q || (arm_q != 16'h0000);
endmodule : dvrs_ramp

// [core/dvrs_sync.sv]
// Two-flop synchroniser for a pin level
`timescale 1ns/10ps
module dvrs_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic q_o
);
    logic s1_q, s2_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
        end
    end
    assign q_o = s2_q;
endmodule : dvrs_sync

// [core/dvrs_top.sv]
// Voltage ramp, protection masking and driver startup sequencer
// Behaviour
// - Strap high keeps single-phase section disabled
// - Commands to disabled single-phase section rejected
// - Mask OV/UV/OC during transitions, delayed re-arm
// - Fast slope 20 mV/us, slow 5 mV/us
// - Step reference toward target at programmed slope
// - New command mid-ramp replaces target
// - Total overcurrent during transition latches disabled
// - Pre-bias startup at power-up and after off
// - Before first pulse: phases high-Z, enable low
// - After first pulse: phases toggle, enable high
// - Overvoltage may still turn low-side on
// - Memory mode with droop: droop times quarter
// - Adjustable droop gain on summed phase current
//
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
module dvrs_top
    import dvrs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic single_phase_disable_strap_i,
    input wire logic ov_i,
    input wire logic uv_i,
    input wire logic oc_i,
    input wire logic oc_total_i,
    input wire logic [dvrs_pkg::SECT_N-1:0] mod_pulse_i,
    input wire logic [dvrs_pkg::CUR_W-1:0] phase_cur_sum_i,
    output logic [dvrs_pkg::SECT_N-1:0] phase_modulator_out_o,
    output logic [dvrs_pkg::SECT_N-1:0] phase_modulator_oe_n_o,
    output logic [dvrs_pkg::SECT_N-1:0] driver_enable_out_o,
    output logic [dvrs_pkg::SECT_N-1:0] low_side_on_o,
    output logic [dvrs_pkg::VID_W-1:0] ref0_o,
    output logic [dvrs_pkg::VID_W-1:0] ref1_o,
    output logic [dvrs_pkg::CUR_W-1:0] droop_cur_o,
    output logic fault_o
);
    logic strap_s, ov_s, uv_s, oc_s, oct_s;
    logic [SECT_N-1:0] pulse_s;
    logic wr, rd, cmd_ok, rej;
    logic [SECT_N-1:0] cmd, busy, mask, done;
    logic [VID_W-1:0] ref0, ref1;
    logic [EV_W-1:0] irq_q, irq_d, mask_q, mask_d, ev;
    logic [9:0] cfg_q, cfg_d;
    logic [31:0] dat_d;
    logic ack_d;
    dvrs_st_t st_q [SECT_N], st_d [SECT_N];
    logic [SECT_N-1:0] pwm_d, oe_n_d, en_d, ls_d;
    logic fault_q, fault_d;
    logic [CUR_W+GAIN_W-1:0] prod;
    logic [CUR_W-1:0] droop_d;

    dvrs_sync u_s_strap (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(single_phase_disable_strap_i),
        .q_o(strap_s)
    );
    dvrs_sync u_s_ov (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(ov_i),
        .q_o(ov_s)
    );
    dvrs_sync u_s_uv (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(uv_i),
        .q_o(uv_s)
    );
    dvrs_sync u_s_oc (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(oc_i),
        .q_o(oc_s)
    );
    dvrs_sync u_s_oct (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(oc_total_i),
        .q_o(oct_s)
    );
    dvrs_sync u_s_p0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(mod_pulse_i[0]),
        .q_o(pulse_s[0])
    );
    dvrs_sync u_s_p1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(mod_pulse_i[1]),
        .q_o(pulse_s[1])
    );

    // Bus decode
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    assign cmd_ok = wr && (wb_adr_i == ADR_CMD) && wb_sel_i[0] && wb_sel_i[1];
    always_comb begin
        cmd = '0;
        rej = 1'b0;
        if (cmd_ok && !fault_q) begin
            if (wb_dat_i[CMD_SEC_BIT] && strap_s) begin
                rej = 1'b1;
            end else begin
                cmd[wb_dat_i[CMD_SEC_BIT]] = 1'b1;
            end
        end
    end

    dvrs_ramp u_ramp0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cmd_i(cmd[0]),
        .slow_i(wb_dat_i[CMD_SLOW_BIT]),
        .vid_i(wb_dat_i[CMD_VID_LSB +: VID_W]),
        .ref_o(ref0),
        .busy_o(busy[0]),
        .mask_o(mask[0]),
        .done_o(done[0])
    );
    dvrs_ramp u_ramp1 (
        .clk_i(clk_i),
        .rst_i(rst_i || strap_s),
        .cmd_i(cmd[1]),
        .slow_i(wb_dat_i[CMD_SLOW_BIT]),
        .vid_i(wb_dat_i[CMD_VID_LSB +: VID_W]),
        .ref_o(ref1),
        .busy_o(busy[1]),
        .mask_o(mask[1]),
        .done_o(done[1])
    );

    // Protection and latch
    always_comb begin
        fault_d = fault_q;
        if (oct_s) begin
            fault_d = 1'b1;
        end
        if (!(|mask) && (ov_s || uv_s || oc_s)) begin
            fault_d = 1'b1;
        end
    end

    // Per-section driver sequencing
    always_comb begin
        for (int i = 0; i < SECT_N; i++) begin
            st_d[i] = st_q[i];
            pwm_d[i] = 1'b0;
            oe_n_d[i] = 1'b1;
            en_d[i] = 1'b0;
            ls_d[i] = 1'b0;
            case (st_q[i])
                DVRS_OFF: begin
                    if ((i == 1) ? (ref1 != VID_OFF && !strap_s) : (ref0 != VID_OFF)) begin
                        st_d[i] = DVRS_SOFT;
                    end
                end
                DVRS_SOFT: begin
                    oe_n_d[i] = 1'b1;
                    en_d[i] = 1'b0;
                    if (pulse_s[i]) begin
                        st_d[i] = DVRS_RUN;
                    end
                end
                DVRS_RUN: begin
                    oe_n_d[i] = 1'b0;
                    en_d[i] = 1'b1;
                    pwm_d[i] = pulse_s[i];
                    if ((i == 1) ? (ref1 == VID_OFF || strap_s) : (ref0 == VID_OFF)) begin
                        st_d[i] = DVRS_OFF;
                    end
                end
                DVRS_LATCH: begin
                    oe_n_d[i] = 1'b1;
                end
                default: begin
                    st_d[i] = DVRS_OFF;
                end
            endcase
            if (i == 1 && strap_s) begin
                oe_n_d[i] = 1'b1;
                en_d[i] = 1'b0;
            end
            if (fault_d) begin
                st_d[i] = DVRS_LATCH;
                oe_n_d[i] = 1'b1;
                en_d[i] = 1'b0;
            end
            if (ov_s && !mask[i]) begin
                ls_d[i] = 1'b1;
            end
        end
    end

    // Droop current
    always_comb begin
        prod = phase_cur_sum_i * cfg_q[CFG_GAIN_LSB +: GAIN_W];
        droop_d = '0;
        if (cfg_q[CFG_DROOP_BIT]) begin
            droop_d = prod[CUR_W+GAIN_W-1 -: CUR_W];
            if (cfg_q[CFG_MEM_BIT]) begin
                droop_d = {2'b00, droop_d[CUR_W-1:2]};
            end
        end
    end

    // Registers and interrupts
    assign ev = {fault_d && !fault_q, rej, done[1], done[0]};
    always_comb begin
        irq_d = irq_q;
        mask_d = mask_q;
        cfg_d = cfg_q;
        dat_d = 32'h0000_0000;
        ack_d = wb_cyc_i && wb_stb_i && !wb_ack_o;
        if (wr && wb_adr_i == ADR_MASK && wb_sel_i[0]) begin
            mask_d = wb_dat_i[EV_W-1:0];
        end
        if (wr && wb_adr_i == ADR_CFG) begin
            if (wb_sel_i[0]) begin
                cfg_d[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                cfg_d[9:8] = wb_dat_i[9:8];
            end
        end
        if (rd) begin
            case (wb_adr_i)
                ADR_STAT: dat_d = {26'h0, strap_s, fault_q, mask, busy};
                ADR_IRQ: begin
                    dat_d = {28'h0, irq_q};
                    irq_d = '0;
                end
                ADR_MASK: dat_d = {28'h0, mask_q};
                ADR_CFG: dat_d = {22'h0, cfg_q};
                ADR_REF: dat_d = {16'h0, ref1, ref0};
                default: dat_d = 32'h0000_0000;
            endcase
        end
        irq_d = irq_d | ev;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= '0;
            mask_q <= '0;
            cfg_q <= {2'b00, GAIN_RST};
            wb_dat_o <= 32'h0000_0000;
            wb_ack_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            irq_q <= irq_d;
            mask_q <= mask_d;
            cfg_q <= cfg_d;
            wb_dat_o <= dat_d;
            wb_ack_o <= ack_d;
            irq_o <= |(irq_d & mask_d);
        end
    end

    // Fault latch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_q <= 1'b0;
            fault_o <= 1'b0;
        end else begin
            fault_q <= fault_d;
            fault_o <= fault_d;
        end
    end

    // Sequencer state and driver pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < SECT_N; i++) begin
                st_q[i] <= DVRS_OFF;
            end
            phase_modulator_out_o <= '0;
            phase_modulator_oe_n_o <= '1;
            driver_enable_out_o <= '0;
            low_side_on_o <= '0;
        end else begin
            for (int i = 0; i < SECT_N; i++) begin
                st_q[i] <= st_d[i];
            end
            phase_modulator_out_o <= pwm_d;
            phase_modulator_oe_n_o <= oe_n_d;
            driver_enable_out_o <= en_d;
            low_side_on_o <= ls_d;
        end
    end

    // Reference and droop outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref0_o <= VID_OFF;
            ref1_o <= VID_OFF;
            droop_cur_o <= '0;
        end else begin
            ref0_o <= ref0;
            ref1_o <= ref1;
            droop_cur_o <= droop_d;
        end
    end
endmodule : dvrs_top

// [verif/dvrs_pstage_model.sv]
// Modulator side: pulses once a section's reference is up
`timescale 1ns/10ps
module dvrs_pstage_model
    import dvrs_pkg::*;
#(
    parameter int LAG = 40,
    parameter int PER = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [dvrs_pkg::VID_W-1:0] ref0_i,
    input wire logic [dvrs_pkg::VID_W-1:0] ref1_i,
    output logic [dvrs_pkg::SECT_N-1:0] pulse_o
);
    int cnt [2] = '{0, 0};
    initial pulse_o = '0;
    always @(posedge clk_i) begin
        for (int s = 0; s < 2; s++) begin
            cnt[s] <= (rst_i || (s ? ref1_i : ref0_i) == 8'h00) ? 0 : cnt[s] + 1;
            pulse_o[s] <= cnt[s] >= LAG && cnt[s] % PER == 0;
        end
    end
endmodule : dvrs_pstage_model

// [verif/dvrs_top_checker.sv]
// Port checker for the ramp and startup sequencer
`timescale 1ns/10ps
module dvrs_top_checker
    import dvrs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic single_phase_disable_strap_i,
    input wire logic oc_total_i,
    input wire logic [dvrs_pkg::SECT_N-1:0] phase_modulator_oe_n_o,
    input wire logic [dvrs_pkg::SECT_N-1:0] driver_enable_out_o,
    input wire logic [dvrs_pkg::VID_W-1:0] ref0_o,
    input wire logic [dvrs_pkg::VID_W-1:0] ref1_o,
    input wire logic fault_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    en_hiz_a: assert property (!fault_o |-> driver_enable_out_o == ~phase_modulator_oe_n_o)
        else $error("enable and drive disagree");
    ref_step_a: assert property (!fault_o && $changed(ref0_o) |->
        (ref0_o == $past(ref0_o) + 8'h01) || (ref0_o == $past(ref0_o) - 8'h01))
        else $error("reference jumped");
    ref_pace_a: assert property (!fault_o && $changed(ref0_o) |=>
        ($stable(ref0_o) || fault_o) [*8])
        else $error("reference too fast");
    strap_hold_a: assert property (single_phase_disable_strap_i [*4] ##0 ref1_o == 8'h00
        |=> ref1_o == 8'h00)
        else $error("disabled section moved");
    fault_trip_a: assert property (oc_total_i [*4] |-> ##[0:4] fault_o)
        else $error("no latch");
    fault_stick_a: assert property (fault_o |=> fault_o)
        else $error("fault released");
endmodule : dvrs_top_checker

bind dvrs_top dvrs_top_checker u_chk (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .single_phase_disable_strap_i,
    .oc_total_i, .phase_modulator_oe_n_o, .driver_enable_out_o, .ref0_o, .ref1_o, .fault_o
);

// [verif/dvrs_top_tb_top.sv]
// Testbench for the ramp and startup sequencer
`timescale 1ns/10ps
module dvrs_top_tb_top;
    import dvrs_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] adr = '0;
    logic [31:0] wdat = '0;
    logic [15:0] cur = '0;
    logic [2:0] bus = '0;
    logic strap = 1'b0;
    logic [3:0] flt = '0;
    logic [31:0] rdat;
    logic ack, irq, fault;
    logic [1:0] pls, pwm, oen, en, lso;
    logic [7:0] r0, r1;
    logic [15:0] droop;
    logic [63:0] expq [$];
    int num_errors = 0;
    int num_checks = 0;
    initial forever #10 clk_i = ~clk_i;
    dvrs_top u_dut (.clk_i, .rst_i, .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_sel_i(4'hf), .wb_we_i(bus[0]), .wb_cyc_i(bus[2]), .wb_stb_i(bus[1]),
        .wb_ack_o(ack), .irq_o(irq), .single_phase_disable_strap_i(strap), .ov_i(flt[3]),
        .uv_i(flt[2]), .oc_i(flt[1]), .oc_total_i(flt[0]), .mod_pulse_i(pls),
        .phase_cur_sum_i(cur), .phase_modulator_out_o(pwm), .phase_modulator_oe_n_o(oen),
        .driver_enable_out_o(en), .low_side_on_o(lso), .ref0_o(r0), .ref1_o(r1),
        .droop_cur_o(droop), .fault_o(fault));
    dvrs_pstage_model u_pst (.clk_i, .rst_i, .ref0_i(r0), .ref1_i(r1), .pulse_o(pls));
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
    endtask : tick
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [31:0] m = 32'hffffffff);
        int n;
        @(posedge clk_i);
        {bus, adr, wdat} <= {2'b11, w, a, d};
        if (!w) expq.push_back({m, d & m});
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        bus <= 3'b000;
        chk(ack, 1'b1);
        if (ack !== 1'b1) end_sim();
    endtask : wb
    task automatic cmd(input logic s, input logic sl, input logic [7:0] v);
        wb(1'b1, ADR_CMD, {22'h0, sl, s, v});
    endtask : cmd
    task automatic wref(input logic s, input logic [7:0] v, output int c);
        c = 0;
        do begin
            @(posedge clk_i);
            c++;
        end while ((s ? r1 : r0) !== v && c < 20000);
        chk(s ? r1 : r0, v);
        if ((s ? r1 : r0) !== v) end_sim();
    endtask : wref
    task automatic reset_dut();
        rst_i <= 1'b1;
        tick(2);
        rst_i <= 1'b0;
        tick(3);
    endtask : reset_dut
    always @(posedge clk_i) begin
        if (ack && !bus[0] && expq.size() > 0) begin
            chk(rdat & expq[0][63:32], expq[0][31:0]);
            void'(expq.pop_front());
        end
    end
    initial begin
        int c;
        logic [7:0] g;
        logic [31:0] e;
        void'($urandom(32'h2b48880e));
        reset_dut();
        chk({r0, r1, oen, en, irq, fault}, 32'h30);
        wb(1'b0, ADR_CFG, 32'h80, 32'h3ff);
        wb(1'b0, 8'h18, 32'h0);
        wb(1'b1, ADR_MASK, 32'h3);
        $display("reset test done");
        cmd(1'b0, 1'b0, 8'h03);
        wref(1'b0, 8'h01, c);
        chk({oen[0], en[0]}, 2'b10);
        wref(1'b0, 8'h02, c);
        chk(c, FAST_STEP_CYC);
        wref(1'b0, 8'h03, c);
        tick(2);
        chk(irq, 1'b1);
        wb(1'b0, ADR_IRQ, 32'h1, 32'h3);
        tick(2);
        chk(irq, 1'b0);
        $display("fast ramp test done");
        cmd(1'b0, 1'b1, 8'h06);
        wref(1'b0, 8'h04, c);
        wref(1'b0, 8'h05, c);
        chk(c, SLOW_STEP_CYC);
        cmd(1'b0, 1'b0, 8'h00);
        c = 0;
        while (r0 === 8'h05 && c < 2000) begin
            tick(1);
            c++;
        end
        chk(r0, 8'h04);
        wref(1'b0, 8'h00, c);
        tick(4);
        chk({oen[0], en[0]}, 2'b10);
        cmd(1'b0, 1'b0, 8'h01);
        wref(1'b0, 8'h01, c);
        chk({oen[0], en[0]}, 2'b10);
        tick(80);
        chk({oen[0], en[0]}, 2'b01);
        c = 0;
        while (pwm[0] !== 1'b1 && c < 40) begin
            tick(1);
            c++;
        end
        chk(pwm[0], 1'b1);
        $display("retarget test done");
        cmd(1'b0, 1'b0, 8'h04);
        tick(10);
        flt <= 4'he;
        tick(4);
        flt <= '0;
        tick(6);
        chk(fault, 1'b0);
        wref(1'b0, 8'h04, c);
        tick(20);
        flt <= 4'he;
        tick(4);
        flt <= '0;
        tick(6);
        chk(fault, 1'b0);
        tick(REARM_CYC);
        flt <= 4'h8;
        tick(6);
        chk({fault, lso[0]}, 2'b11);
        flt <= '0;
        wb(1'b0, ADR_IRQ, 32'h8, 32'h8);
        reset_dut();
        cmd(1'b0, 1'b0, 8'h08);
        tick(30);
        flt <= 4'h1;
        tick(8);
        chk({fault, oen}, 3'b111);
        flt <= '0;
        $display("protection test done");
        strap <= 1'b1;
        reset_dut();
        cmd(1'b1, 1'b0, 8'h05);
        tick(600);
        chk(r1, 8'h00);
        wb(1'b0, ADR_IRQ, 32'h4, 32'h4);
        strap <= 1'b0;
        tick(4);
        cmd(1'b1, 1'b0, 8'h01);
        wref(1'b1, 8'h01, c);
        $display("strap test done");
        for (int i = 0; i < 4; i++) begin
            g = 8'($urandom());
            cur <= 16'($urandom());
            wb(1'b1, ADR_CFG, {22'h0, i[1:0], g});
            e = i[0] ? (32'(cur) * g) >> (i[1] ? 10 : 8) : 32'h0;
            tick(4);
            chk(droop, e);
        end
        $display("droop test done");
        end_sim();
    end
endmodule : dvrs_top_tb_top
